// ---- include/rtp_pkg.sv ----
// constants, types and field layout shared by both ends of the touch panel link
// assumes a single pclk domain of 20 MHz on each end
package rtp_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_UNIT_NS = 1000; // one step of the settling field
  localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_QUARTER_CYC = 4; // host clock quarter period in pclk cycles
  // target address on the link, value arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
  // register indices (8-bit registers)
  localparam logic [3:0] REG_RES_LAST = 4'h7; // 0..7: x, y, z1, z2 as hi/lo pairs
  localparam logic [3:0] REG_CFG0 = 4'h8;
  localparam logic [3:0] REG_CFG1 = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;
  localparam logic [3:0] REG_COUNT = 4'hb;
  localparam logic [7:0] CFG0_RESET = 8'h10;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  // control byte fields
  localparam int CMD_FLAG_BIT = 7;
  localparam int CTL_ADDR_MSB = 6;
  localparam int CTL_ADDR_LSB = 3;
  localparam int CTL_RD_BIT = 2;
  localparam int CMD_FN_MSB = 6;
  localparam int CMD_FN_LSB = 4;
  localparam int CMD_SWRST_BIT = 0;
  // cfg0: [1:0] divider, [3:2] scan mode, [7:4] settling steps
  localparam int CFG0_DIV_MSB = 1;
  localparam int CFG0_MODE_MSB = 3;
  localparam int CFG0_MODE_LSB = 2;
  localparam int CFG0_SET_MSB = 7;
  localparam int CFG0_SET_LSB = 4;
  // cfg1: [0] pin shows touch (1) or result ready (0), [1] ask for 10-bit
  localparam int CFG1_PIN_TOUCH_BIT = 0;
  localparam int CFG1_RES10_BIT = 1;
  // status register bits
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_TOUCH_BIT = 6;
  localparam int STAT_BUSY_BIT = 5;
  // panel driver vector {xp, xn, yp, yn}
  localparam logic [3:0] DRV_IDLE = 4'h1;
  localparam logic [3:0] DRV_X = 4'hc;
  localparam logic [3:0] DRV_Y = 4'h3;
  localparam logic [3:0] DRV_Z = 4'h6;
  typedef enum logic [2:0] {
    CMD_DRV_X = 3'h0, CMD_DRV_Y = 3'h1, CMD_DRV_Z = 3'h2, CMD_CONV_X = 3'h3,
    CMD_CONV_Y = 3'h4, CMD_CONV_Z1 = 3'h5, CMD_CONV_Z2 = 3'h6, CMD_SCAN = 3'h7
  } rtp_cmd_t;
  typedef enum logic [1:0] {
    MODE_SELF = 2'h0, MODE_HOST_START = 2'h1, MODE_HOST_STEP = 2'h2, MODE_RSVD = 2'h3
  } rtp_mode_t;
  typedef enum logic [1:0] {CH_X = 2'h0, CH_Y = 2'h1, CH_Z1 = 2'h2, CH_Z2 = 2'h3} rtp_chan_t;
  typedef enum logic [1:0] {SQ_IDLE = 2'h0, SQ_SETTLE = 2'h1, SQ_START = 2'h2, SQ_WAIT = 2'h3} rtp_seq_t;
  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_ADDR = 2'h1, PH_WR = 2'h2, PH_RD = 2'h3} rtp_phase_t;
  // host side APB map and command word
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam int HCMD_ACK_BIT = 2;
  localparam int HDATA_MSB = 15;
  localparam int HDATA_LSB = 8;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_ACK_BIT = 1;
  typedef enum logic [1:0] {OP_START = 2'h0, OP_STOP = 2'h1, OP_WRITE = 2'h2, OP_READ = 2'h3} rtp_op_t;
endpackage

// ---- include/rtp_link_if.sv ----
// two-wire link between the host controller and the panel sequencer
// the shared data wire is open drain; its level is resolved here from both enables
`timescale 1ns/1ps
interface rtp_link_if;
  logic scl;         // serial clock, made by the host only
  logic host_sda_o;  // host data out (driven low only)
  logic host_sda_oe; // host pulls the wire
  logic dev_sda_o;   // device data out
  logic dev_sda_oe;  // device pulls the wire
  logic sda;         // resolved wire level, pulled up when nobody pulls low
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// ---- design/rtp_panel_seq.sv ----
// device end: two-wire target, register file and panel measurement sequencer
// assumes scl and sda arrive asynchronously and the converter runs on pclk
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - target only, bits timed by host clock
// - write: address, then commands or control/data pairs
// - read: address, then sequential registers
// - control byte sets read pointer
// - pointer kept until rewritten or reset
// - results held readable at any time
// - pin shows result ready when chosen
// - pin shows touch when chosen
// - status register shows ready and touch
// - y: drive y plates, sense x+
// - x: drive x plates, sense y
// - two cross-panel pressure conversions
// - host should use 10-bit for pressure
// - settling delay before conversion in scans
// - drivers-only command without conversion
// - self-started mode scans on touch
// - host-started mode: host starts, device sequences
// - host-stepped mode: host issues every step
// - divider zero limits to 10 bits
// - idle: y- grounded, touch from x+
module rtp_panel_seq
  import rtp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  rtp_link_if.device link,
  // panel
  input wire logic touch_n,
  output logic [3:0] panel_drv,
  output rtp_pkg::rtp_chan_t adc_sel,
  // converter
  output logic adc_start,
  output logic adc_res12,
  output logic [1:0] adc_clk_div,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  // status pin
  output logic irq_status_output
);
  import rtp_pkg::*;

  // two-flop synchronisers plus an edge-history flop on the scl and sda second stages
  logic [1:0] scl_sy_q, sda_sy_q, tch_sy_q;
  logic scl_d_q, sda_d_q;
  // link state
  rtp_phase_t phase_q;
  logic [3:0] bcnt_q;    // bit count within a byte, 8 is the ack slot
  logic [7:0] sh_q;      // incoming shift register
  logic [7:0] tx_q;      // outgoing byte
  logic pull_q;          // device pulls sda low
  logic [3:0] ptr_q;     // static read pointer
  logic [3:0] rd_idx_q;  // running index within one read
  logic pend_q;          // a data byte is expected next
  logic [3:0] wr_reg_q;
  // registers
  logic [7:0] cfg0_q, cfg1_q;
  logic [11:0] res_q [4];
  logic ready_q, irq_q;
  // sequencer
  rtp_seq_t st_q;
  rtp_chan_t ch_q;
  logic scan_q, hold_q;
  logic [3:0] drv_q;
  logic [15:0] set_cnt_q;

  // edges and bus conditions seen in pclk
  wire scl_s = scl_sy_q[1];
  wire sda_s = sda_sy_q[1];
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire bus_start = scl_s & scl_d_q & ~sda_s & sda_d_q;
  wire bus_stop = scl_s & scl_d_q & sda_s & ~sda_d_q;
  wire byte_end = scl_fall & (bcnt_q == 4'd7);
  wire ack_end = scl_fall & (bcnt_q == 4'd8);
  // decoded write events
  wire wr_ev = byte_end & (phase_q == PH_WR);
  wire data_ev = wr_ev & pend_q;
  wire cmd_ev = wr_ev & ~pend_q & sh_q[CMD_FLAG_BIT];
  wire ctl_ev = wr_ev & ~pend_q & ~sh_q[CMD_FLAG_BIT];
  wire [3:0] ctl_reg = sh_q[CTL_ADDR_MSB:CTL_ADDR_LSB];
  wire soft_rst = cmd_ev & sh_q[CMD_SWRST_BIT];
  wire rtp_cmd_t cmd_fn = rtp_cmd_t'(sh_q[CMD_FN_MSB:CMD_FN_LSB]);
  wire rd_load = ack_end & (phase_q == PH_RD);
  wire addr_hit = sh_q[7:1] == DEV_ADDR;
  // configuration fields
  wire rtp_mode_t mode = rtp_mode_t'(cfg0_q[CFG0_MODE_MSB:CFG0_MODE_LSB]);
  wire [15:0] settle_cyc = 16'(cfg0_q[CFG0_SET_MSB:CFG0_SET_LSB] * SETTLE_UNIT_CYC);
  // touch sensed only while the panel rests in power-down
  wire touch = ~tch_sy_q[1] & (st_q == SQ_IDLE) & ~hold_q;
  wire [7:0] status = {ready_q, touch, st_q != SQ_IDLE, 5'h00};
  // read mux: results as hi/lo pairs, then config and status
  wire [11:0] res_sel = res_q[rd_idx_q[2:1]];
  wire [7:0] res_byte = rd_idx_q[0] ? res_sel[7:0] : {4'h0, res_sel[11:8]};
  wire [7:0] rd_byte = (rd_idx_q <= REG_RES_LAST) ? res_byte :
                       (rd_idx_q == REG_CFG0) ? cfg0_q :
                       (rd_idx_q == REG_CFG1) ? cfg1_q :
                       (rd_idx_q == REG_STATUS) ? status : 8'h00;
  // sequencer triggers
  wire idle = st_q == SQ_IDLE;
  wire self_go = (mode == MODE_SELF) & touch & ~ready_q;
  wire host_scan = cmd_ev & (cmd_fn == CMD_SCAN) & (mode != MODE_HOST_STEP);
  wire single = cmd_ev & (cmd_fn >= CMD_CONV_X) & (cmd_fn != CMD_SCAN);
  wire drv_only = cmd_ev & (cmd_fn <= CMD_DRV_Z);
  wire conv_end = (st_q == SQ_WAIT) & adc_done;
  wire last_conv = conv_end & (~scan_q | (ch_q == CH_Z2));

  // synchronisers; first stages feed only second stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      tch_sy_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], link.scl};
      sda_sy_q <= {sda_sy_q[0], link.sda};
      tch_sy_q <= {tch_sy_q[0], touch_n};
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // target bit engine: every action hangs off a sampled host clock edge or a start/stop condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_IDLE;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      pull_q <= 1'b0;
    end else if (bus_start) begin
      // start or repeated start always restarts addressing
      phase_q <= PH_ADDR;
      // the host clock fall that follows a start carries no bit: it wraps this to zero
      bcnt_q <= 4'hf;
      pull_q <= 1'b0;
    end else if (bus_stop) begin
      phase_q <= PH_IDLE;
      pull_q <= 1'b0;
    end else if (scl_rise) begin
      if (bcnt_q < 4'd8 && phase_q != PH_RD) begin
        sh_q <= {sh_q[6:0], sda_s};
      end else if (bcnt_q == 4'd8 && phase_q == PH_RD && sda_s) begin
        // host declined more data: end of the read
        phase_q <= PH_IDLE;
      end
    end else if (byte_end) begin
      bcnt_q <= 4'd8;
      if (phase_q == PH_ADDR) begin
        // read or write direction from the address byte
        pull_q <= addr_hit;
        phase_q <= !addr_hit ? PH_IDLE : (sh_q[0] ? PH_RD : PH_WR);
      end else begin
        // acknowledge written bytes, release for the host ack on reads
        pull_q <= phase_q == PH_WR;
      end
    end else if (ack_end) begin
      bcnt_q <= 4'h0;
      // next register goes out msb first
      tx_q <= rd_byte;
      pull_q <= rd_load & ~rd_byte[7];
    end else if (scl_fall && phase_q != PH_IDLE) begin
      bcnt_q <= bcnt_q + 4'h1;
      tx_q <= {tx_q[6:0], 1'b0};
      pull_q <= (phase_q == PH_RD) & ~tx_q[6];
    end
  end

  // pointer and write decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 4'h0;
      rd_idx_q <= 4'h0;
      pend_q <= 1'b0;
      wr_reg_q <= 4'h0;
    end else if (soft_rst) begin
      ptr_q <= 4'h0;
      pend_q <= 1'b0;
    end else begin
      // pointer only moves on a new control byte or a software reset
      if (byte_end && phase_q == PH_ADDR) begin
        rd_idx_q <= ptr_q;
      end else if (rd_load) begin
        rd_idx_q <= rd_idx_q + 4'h1;
      end
      // control byte names the register and the access
      if (ctl_ev) begin
        ptr_q <= ctl_reg;
        wr_reg_q <= ctl_reg;
        pend_q <= ~sh_q[CTL_RD_BIT];
      end else if (data_ev || bus_start) begin
        pend_q <= 1'b0;
      end
    end
  end

  // configuration registers, written by control/data pairs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= CFG0_RESET;
      cfg1_q <= CFG1_RESET;
    end else if (soft_rst) begin
      cfg0_q <= CFG0_RESET;
      cfg1_q <= CFG1_RESET;
    end else if (data_ev) begin
      if (wr_reg_q == REG_CFG0) cfg0_q <= sh_q;
      if (wr_reg_q == REG_CFG1) cfg1_q <= sh_q;
    end
  end

  // measurement sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SQ_IDLE;
      ch_q <= CH_X;
      scan_q <= 1'b0;
      hold_q <= 1'b0;
      set_cnt_q <= 16'h0000;
    end else if (soft_rst) begin
      st_q <= SQ_IDLE;
      hold_q <= 1'b0;
    end else begin
      case (st_q)
        SQ_IDLE: begin
          if (self_go || host_scan) begin
            // full scan sequenced here, x first
            ch_q <= CH_X;
            scan_q <= 1'b1;
            set_cnt_q <= settle_cyc;
            st_q <= SQ_SETTLE;
          end else if (single) begin
            // one conversion as commanded, host did its own settling
            ch_q <= rtp_chan_t'(2'(cmd_fn - CMD_CONV_X));
            scan_q <= 1'b0;
            st_q <= SQ_START;
          end else if (drv_only) begin
            ch_q <= rtp_chan_t'(2'(cmd_fn));
            hold_q <= 1'b1;
          end
        end
        SQ_SETTLE: begin
          if (set_cnt_q == 16'h0000) st_q <= SQ_START;
          else set_cnt_q <= set_cnt_q - 16'h0001;
        end
        SQ_START: st_q <= SQ_WAIT;
        SQ_WAIT: begin
          if (last_conv) begin
            st_q <= SQ_IDLE;
            scan_q <= 1'b0;
            hold_q <= 1'b0;
          end else if (conv_end) begin
            // scan continues through both pressure channels
            ch_q <= rtp_chan_t'(2'(ch_q + 2'h1));
            set_cnt_q <= settle_cyc;
            st_q <= SQ_SETTLE;
          end
        end
        default: st_q <= SQ_IDLE;
      endcase
    end
  end

  // results, ready flag and status pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '{default: 12'h000};
      ready_q <= 1'b0;
      irq_q <= 1'b0;
      drv_q <= DRV_IDLE;
    end else begin
      if (soft_rst) res_q <= '{default: 12'h000};
      else if (conv_end) res_q[ch_q] <= adc_data;
      // result read clears, a finishing conversion wins
      if (last_conv) ready_q <= 1'b1;
      else if (soft_rst || (rd_load && rd_idx_q <= REG_RES_LAST)) ready_q <= 1'b0;
      irq_q <= cfg1_q[CFG1_PIN_TOUCH_BIT] ? touch : ready_q;
      // drivers follow the channel; y- only when resting
      if (idle && !hold_q) drv_q <= DRV_IDLE;
      else drv_q <= (ch_q == CH_X) ? DRV_X : (ch_q == CH_Y) ? DRV_Y : DRV_Z;
    end
  end

  // outputs
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = pull_q;
  assign panel_drv = drv_q;
  assign adc_sel = ch_q;
  assign adc_start = st_q == SQ_START;
  assign adc_clk_div = cfg0_q[CFG0_DIV_MSB:0];
  // twelve bits only with a divided converter clock
  assign adc_res12 = ~cfg1_q[CFG1_RES10_BIT] & (adc_clk_div != 2'h0);
  // status register carries both flags whatever the pin shows
  assign irq_status_output = irq_q;
endmodule

// ---- design/rtp_host_ctrl.sv ----
// host end: APB-programmed two-wire controller that makes the serial clock
// assumes software writes one link operation at a time and polls the status word
`timescale 1ns/1ps
module rtp_host_ctrl
  import rtp_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  rtp_link_if.host link
);
  import rtp_pkg::*;

  logic [1:0] sda_sy_q;   // wire level synchroniser
  logic busy_q;
  rtp_op_t op_q;
  logic [7:0] tx_q;
  logic ack_send_q;       // read: acknowledge this byte
  logic [8:0] rx_q;       // data bits then the ack bit
  logic [3:0] bit_q;
  logic [1:0] ph_q;       // quarter of the current bit slot
  logic [7:0] cnt_q;
  logic scl_q, pull_q;
  logic [31:0] prdata_q;

  // apb decode
  wire hit_cmd = paddr == HOST_CMD_OFS;
  wire hit_stat = paddr == HOST_STAT_OFS;
  wire access = psel & penable;
  wire cmd_wr = access & pwrite & hit_cmd & ~busy_q;
  wire [31:0] stat_word = {16'h0000, rx_q[8:1], 6'h00, ~rx_q[0], busy_q};
  // quarter ticks and end of an operation
  wire tick = cnt_q == 8'(QUARTER - 1);
  wire is_byte = op_q == OP_WRITE || op_q == OP_READ;
  wire last = tick & (ph_q == 2'h3) & (~is_byte | (bit_q == 4'd8));
  // level that the data wire takes in a byte slot
  wire bit_pull = (bit_q < 4'd8) ? (op_q == OP_WRITE) & ~tx_q[7] :
                                   (op_q == OP_READ) & ack_send_q;

  // apb register access, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      sda_sy_q <= 2'h3;
    end else begin
      sda_sy_q <= {sda_sy_q[0], link.sda};
      if (psel && !penable) prdata_q <= hit_stat ? stat_word : 32'h0000_0000;
    end
  end

  // bit engine: host alone makes the serial clock by dividing pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      op_q <= OP_STOP;
      tx_q <= 8'h00;
      ack_send_q <= 1'b0;
      rx_q <= 9'h000;
      bit_q <= 4'h0;
      ph_q <= 2'h0;
      cnt_q <= 8'h00;
      scl_q <= 1'b1;
      pull_q <= 1'b0;
    end else if (cmd_wr) begin
      // one start, stop or byte per command word
      busy_q <= 1'b1;
      op_q <= rtp_op_t'(pwdata[1:0]);
      tx_q <= pwdata[HDATA_MSB:HDATA_LSB];
      ack_send_q <= pwdata[HCMD_ACK_BIT];
      bit_q <= 4'h0;
      ph_q <= 2'h0;
      cnt_q <= 8'h00;
    end else if (busy_q) begin
      cnt_q <= tick ? 8'h00 : cnt_q + 8'h01;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (ph_q)
          2'h0: begin
            scl_q <= 1'b0;
            pull_q <= (op_q == OP_STOP) | (is_byte & bit_pull);
            if (op_q == OP_START) pull_q <= 1'b0;
          end
          2'h1: scl_q <= 1'b1;
          2'h2: begin
            // start pulls, stop releases data while the clock is high
            if (op_q == OP_START) pull_q <= 1'b1;
            else if (op_q == OP_STOP) pull_q <= 1'b0;
            else rx_q <= {rx_q[7:0], sda_sy_q[1]};
          end
          default: begin
            if (op_q != OP_STOP) scl_q <= 1'b0;
            bit_q <= bit_q + 4'h1;
            tx_q <= {tx_q[6:0], 1'b0};
            if (last) busy_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // outputs
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access & ~(hit_cmd | hit_stat);
  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = pull_q;
endmodule

// ---- test/rtp_link_sva.sv ----
// checker on the link wires and on the panel outputs of the device end
// assumes one pclk domain; the bench instantiates it beside the link
`timescale 1ns/1ps
module rtp_link_sva
  import rtp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // panel side of the device
  input wire logic [3:0] panel_drv,
  input wire rtp_pkg::rtp_chan_t adc_sel,
  input wire logic adc_start
);
  import rtp_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // open drain: a high level on the wire comes only from the pull-up
  AST_OD_LOW: assert property (!host_sda_o && !dev_sda_o)
    else $error("sda output driven high");
  // the device starts pulling only inside a low phase of the host clock
  AST_PULL_SCL_LOW: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device pulled sda while scl high");
  // a change during scl high would read as a start or stop
  AST_HOLD_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device sda changed while scl high");
  // every conversion sees the drivers of its own channel
  AST_DRV_Y: assert property (adc_start && adc_sel == CH_Y |-> panel_drv == DRV_Y)
    else $error("y conversion without y drivers");
  AST_DRV_X: assert property (adc_start && adc_sel == CH_X |-> panel_drv == DRV_X)
    else $error("x conversion without x drivers");
  AST_DRV_Z: assert property (adc_start && adc_sel[1] |-> panel_drv == DRV_Z)
    else $error("pressure conversion without cross drivers");
  // start is a single pulse, never a level
  AST_START_PULSE: assert property (adc_start |=> !adc_start)
    else $error("converter start longer than one cycle");
  // channel and drivers held while the converter samples
  AST_HOLD_CONV: assert property ($rose(adc_start) |=>
    ($stable(adc_sel) && $stable(panel_drv)) [*3])
    else $error("channel or drivers moved during conversion");
endmodule

// ---- test/tb_top.sv ----
// bench: the apb host controller drives the panel sequencer over the shared link
// assumes default link speed; the converter model answers three cycles late
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
  import rtp_pkg::*;
  // apb side
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  // panel and converter
  logic touch_n = 1'b1, adc_done = 1'b0, scanning = 1'b0, lowres = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic [3:0] panel_drv, drv_prev = 4'h0;
  logic adc_start, adc_res12, irq_status_output;
  logic [1:0] adc_clk_div;
  rtp_chan_t adc_sel, ch_q = CH_X;
  // bookkeeping
  int miscompares = 0, tests_run = 0, nstart = 0, dly = 0, drv_age = 0;
  logic [7:0] ex[8]; // expected bytes, indexed by register modulo 8
  logic [3:0] drv_tab[3] = '{DRV_X, DRV_Y, DRV_Z};
  rtp_link_if link();
  rtp_host_ctrl rtp_host_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(link));
  rtp_panel_seq rtp_panel_seq_inst (.pclk, .presetn, .link(link), .touch_n, .panel_drv,
    .adc_sel, .adc_start, .adc_res12, .adc_clk_div, .adc_done, .adc_data, .irq_status_output);
  rtp_link_sva rtp_link_sva_inst (.pclk, .presetn, .scl(link.scl),
    .host_sda_o(link.host_sda_o), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .panel_drv, .adc_sel, .adc_start);
  // 20 MHz clock
  initial forever #25 pclk = ~pclk;
  // converter code per channel, distinct in every nibble
  function automatic logic [11:0] ad(input logic [1:0] c);
    return 12'h9a4 + 12'h123 * {10'h0, c};
  endfunction
  // converter model; also times how long the drivers have stood
  always @(posedge pclk) begin
    adc_done <= (dly == 1) && (adc_start !== 1'b1);
    adc_data <= ad(ch_q);
    drv_prev <= panel_drv;
    // cycles the drivers have stood, the cycle of the change included
    drv_age <= (panel_drv !== drv_prev) ? 1 : drv_age + 1;
    dly <= (adc_start === 1'b1) ? 3 : ((dly > 0) ? dly - 1 : 0);
    if (adc_start === 1'b1) begin
      `CHK(adc_res12, (adc_clk_div != 2'h0) && !lowres)
      if (scanning) `CHK(adc_sel, rtp_chan_t'(nstart[1:0]))
      if (scanning) `CHK(drv_age >= SETTLE_UNIT_CYC, 1'b1)
      nstart <= nstart + 1;
      ch_q <= adc_sel;
    end
  end
  // verdict and end of run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    final_report();
  endtask
  // one apb transfer, request held until pready at an access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one link operation, then poll the busy bit
  task automatic op(input rtp_op_t o, input logic [7:0] b, input logic ak,
      output logic [31:0] st);
    logic e;
    int n;
    n = 0;
    apb(1'b1, HOST_CMD_OFS, {16'h0, b, 5'h0, ak, o}, st, e);
    do begin
      apb(1'b0, HOST_STAT_OFS, 32'h0, st, e);
      n++;
    end while (st[HSTAT_BUSY_BIT] !== 1'b0 && n < 400);
    if (n >= 400) hang();
  endtask
  task automatic wbyte(input logic [7:0] b, input logic ack);
    logic [31:0] st;
    op(OP_WRITE, b, 1'b0, st);
    `CHK(st[HSTAT_ACK_BIT], ack)
  endtask
  // write frame with one or two bytes after the address
  task automatic wframe(input logic [7:0] b0, input logic [7:0] b1, input logic two);
    logic [31:0] st;
    op(OP_START, 8'h00, 1'b0, st);
    wbyte({DEV_ADDR_DEFAULT, 1'b0}, 1'b1);
    wbyte(b0, 1'b1);
    if (two) wbyte(b1, 1'b1);
    op(OP_STOP, 8'h00, 1'b0, st);
  endtask
  // read frame of n bytes; the last byte is refused so the device lets go
  task automatic rframe(input logic [3:0] r, input logic setp, input int n);
    logic [31:0] st;
    if (setp) wframe({1'b0, r, 3'h4}, 8'h00, 1'b0);
    op(OP_START, 8'h00, 1'b0, st);
    wbyte({DEV_ADDR_DEFAULT, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      op(OP_READ, 8'h00, i < n - 1, st);
      `CHK(st[HDATA_MSB:HDATA_LSB], ex[(r + i) % 8])
    end
    op(OP_STOP, 8'h00, 1'b0, st);
  endtask
  task automatic fill(input int c);
    logic [11:0] d;
    d = ad(c[1:0]);
    ex[2 * c] = {4'h0, d[11:8]};
    ex[2 * c + 1] = d[7:0];
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_status_output !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) hang();
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // unmapped host address is refused with zero data
    apb(1'b0, 8'h40, 32'h0, rd, er);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    // a frame for another target stays unanswered
    op(OP_START, 8'h00, 1'b0, rd);
    wbyte(8'h56, 1'b0);
    op(OP_STOP, 8'h00, 1'b0, rd);
    // two registers written, read in sequence, then again through the kept pointer
    wframe({1'b0, REG_CFG0, 3'h0}, 8'h19, 1'b1);
    wframe({1'b0, REG_CFG1, 3'h0}, 8'h01, 1'b1);
    ex[0] = 8'h19;
    ex[1] = 8'h01;
    ex[2] = 8'h40;
    rframe(REG_CFG0, 1'b1, 2);
    rframe(REG_CFG0, 1'b0, 1);
    // touch on the pin and in the status byte
    touch_n <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(irq_status_output, 1'b1)
    rframe(REG_STATUS, 1'b1, 1);
    touch_n <= 1'b1;
    wframe({1'b0, REG_CFG1, 3'h0}, 8'h00, 1'b1);
    `CHK(irq_status_output, 1'b0)
    // host-stepped: drivers only, then one conversion per channel
    for (int c = 0; c < 4; c++) begin
      // pressure asks for the short conversion; both pressure channels share drivers
      if (c == 2) wframe({1'b0, REG_CFG1, 3'h0}, 8'h02, 1'b1);
      lowres = c >= 2;
      wframe({1'b1, 3'((c < 3) ? c : 2), 4'h0}, 8'h00, 1'b0);
      `CHK(panel_drv, drv_tab[(c < 3) ? c : 2])
      wframe({1'b1, 3'(c + 3), 4'h0}, 8'h00, 1'b0);
      wait_irq();
      fill(c);
      rframe(4'(2 * c), 1'b1, 2);
      `CHK(irq_status_output, 1'b0)
      `CHK(panel_drv, DRV_IDLE)
    end
    // full resolution asked for again before the scans
    wframe({1'b0, REG_CFG1, 3'h0}, 8'h00, 1'b1);
    lowres = 1'b0;
    // self-started scan, then host-started scan with the divider at zero
    for (int m = 0; m < 2; m++) begin
      wframe({1'b0, REG_CFG0, 3'h0}, (m == 0) ? 8'h11 : 8'h14, 1'b1);
      nstart = 0;
      scanning = 1'b1;
      touch_n <= 1'b0;
      if (m == 1) wframe({1'b1, CMD_SCAN, 4'h0}, 8'h00, 1'b0);
      wait_irq();
      touch_n <= 1'b1;
      scanning = 1'b0;
      `CHK(nstart, 4)
      for (int c = 0; c < 4; c++) fill(c);
      rframe(4'h0, 1'b1, 8);
      `CHK(irq_status_output, 1'b0)
    end
    // software reset clears the results and restores the configuration
    wframe({1'b1, 3'h0, 4'h1}, 8'h00, 1'b0);
    ex[0] = 8'h00;
    rframe(4'h0, 1'b0, 1);
    ex[0] = CFG0_RESET;
    rframe(REG_CFG0, 1'b1, 1);
    final_report();
  end
endmodule
